// File: bench/raoc_host_model.sv
// host controller model: issues bus commands into the block
`timescale 1ns/10ps
module raoc_host_model (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output logic [6:0] cmd_addr_out,
    output logic cmd_read_out,
    output logic cmd_setpoint_out,
    output logic cmd_output_out,
    output logic [15:0] cmd_data_out
);
    initial begin
        cmd_valid_out = 1'b0;
        {cmd_addr_out, cmd_read_out, cmd_setpoint_out, cmd_output_out, cmd_data_out} = '0;
    end
    // held until the taking edge; last=0 keeps valid up for a back-to-back command
    task automatic issue(input logic [6:0] a, input logic rd, input logic sp, input logic op,
        input logic [15:0] d, input logic rogue, input logic last);
        if (a == 7'h00 && !rogue) rd = 1'b0;
        // a back-to-back command finds valid already up and leaves it alone
        if (!cmd_valid_out) cmd_valid_out = 1'b1;
        {cmd_addr_out, cmd_read_out, cmd_setpoint_out, cmd_output_out, cmd_data_out} = {a, rd, sp, op, d};
        @(posedge clk_in);
        #1;
        cmd_valid_out = !last;
        // released fields must not look like the last command
        if (last) {cmd_addr_out, cmd_data_out} = {~a, ~d};
    endtask
endmodule

// File: bench/raoc_props.sv
// checker: timing relations at the ports of the address and output control top
`timescale 1ns/10ps
module raoc_props (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic protocol_strap_open_in,
    input wire logic slot_sense_tied_in,
    input wire logic interlock_tied_in,
    input wire logic on_off_n_in,
    input wire logic cmd_valid_in,
    input wire logic [6:0] cmd_addr_in,
    input wire logic cmd_read_in,
    input wire logic cmd_setpoint_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic [6:0] bus_address_out,
    input wire logic address_valid_out,
    input wire logic rs485_mode_out,
    input wire logic ack_out,
    input wire logic invalid_cmd_out,
    input wire logic [15:0] setpoint_out,
    input wire logic sw_owns_out,
    input wire logic main_output_on_out
);
    // ------------------------------------------------------------
    // assertions, one clock domain
    // ------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_bcast_write_ack: assert property (
        cmd_valid_in && cmd_addr_in == 7'h00 && !cmd_read_in |=> ack_out)
        else $error("broadcast write not acknowledged");
    a_bcast_read_flag: assert property (
        cmd_valid_in && cmd_addr_in == 7'h00 && cmd_read_in |=> invalid_cmd_out)
        else $error("broadcast read did not flag invalid command");
    a_ack_has_cause: assert property (
        ack_out |-> $past(cmd_valid_in))
        else $error("acknowledge without a command");
    a_addr_prefix_ok: assert property (
        address_valid_out |-> bus_address_out[6:4] == 3'b100 && !$past(rs485_mode_out))
        else $error("bus address prefix wrong or valid in rs485 mode");
    a_mode_from_strap: assert property (
        !$past(reset_in) |-> rs485_mode_out == !$past(protocol_strap_open_in))
        else $error("mode does not follow protocol strap");
    a_out_needs_interlock: assert property (
        main_output_on_out |-> $past(interlock_tied_in) && $past(slot_sense_tied_in))
        else $error("output on without interlock and slot sense");
    a_onoff_gates_out: assert property (
        on_off_n_in && protocol_strap_open_in && !rs485_mode_out |=> !main_output_on_out)
        else $error("output on while on/off released in two-wire mode");
    a_sw_setpoint_takes: assert property (
        cmd_valid_in && cmd_setpoint_in && !cmd_read_in && cmd_addr_in == 7'h00
        |-> ##2 sw_owns_out && setpoint_out == $past(cmd_data_in, 2))
        else $error("software setpoint not taken");
    c_bcast_read: cover property (cmd_valid_in && cmd_addr_in == 7'h00 && cmd_read_in);
    c_sw_takes: cover property ($rose(sw_owns_out));
    c_output_on: cover property ($rose(main_output_on_out));
endmodule
bind raoc_top raoc_props chk (.clk_in, .reset_in, .protocol_strap_open_in, .slot_sense_tied_in,
    .interlock_tied_in, .on_off_n_in, .cmd_valid_in, .cmd_addr_in, .cmd_read_in, .cmd_setpoint_in,
    .cmd_data_in, .bus_address_out, .address_valid_out, .rs485_mode_out, .ack_out, .invalid_cmd_out,
    .setpoint_out, .sw_owns_out, .main_output_on_out);

// File: bench/tb_top.sv
// testbench: address decode, output gating, setpoint handover and broadcast handling
`timescale 1ns/10ps
module tb_top;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] unit_position_strap_in, rack_position_strap_in, slot_position_strap_in;
    logic [11:0] shelf_position_level_in, vprog_mv_in;
    logic protocol_strap_open_in, slot_sense_tied_in, interlock_tied_in, on_off_n_in;
    logic cmd_valid_in, cmd_read_in, cmd_setpoint_in, cmd_output_in, address_valid_out, rs485_mode_out;
    logic ack_out, invalid_cmd_out, sw_owns_out, main_output_on_out;
    logic [6:0] cmd_addr_in, bus_address_out;
    logic [15:0] cmd_data_in, setpoint_out;
    logic [3:0] bay_code_out, slot_code_out, shelf_code_out;
    logic [11:0] unit_mv [1:10] = '{12'hbb8, 12'ha6e, 12'h924, 12'h7da, 12'h690, 12'h546, 12'h3fc,
        12'h2b2, 12'h168, 12'h000};
    logic [11:0] rack_mv [1:8] = '{12'hce4, 12'haf0, 12'h8fc, 12'h708, 12'h578, 12'h3e8, 12'h1f4, 12'h000};
    logic [23:0] exp_q [$];
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    raoc_top dut (.clk_in, .reset_in, .unit_position_strap_in, .rack_position_strap_in,
        .slot_position_strap_in, .shelf_position_level_in, .vprog_mv_in, .protocol_strap_open_in,
        .slot_sense_tied_in, .interlock_tied_in, .on_off_n_in, .cmd_valid_in, .cmd_addr_in, .cmd_read_in,
        .cmd_setpoint_in, .cmd_output_in, .cmd_data_in, .bus_address_out, .address_valid_out, .bay_code_out,
        .slot_code_out, .shelf_code_out, .rs485_mode_out, .ack_out, .invalid_cmd_out, .setpoint_out,
        .sw_owns_out, .main_output_on_out);
    raoc_host_model host (.clk_in, .cmd_valid_out(cmd_valid_in), .cmd_addr_out(cmd_addr_in),
        .cmd_read_out(cmd_read_in), .cmd_setpoint_out(cmd_setpoint_in), .cmd_output_out(cmd_output_in),
        .cmd_data_out(cmd_data_in));
    initial forever #12.5 clk_in = ~clk_in;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic put(input logic [3:0] k, input logic [19:0] v);
        exp_q.push_back({k, v});
    endtask
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("samples_checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [4:0] exp_addr(input int u, input int r);
        if (u <= 4 && r <= 4) return {1'b1, 4'(4 * (r - 1) + u - 1)};
        if (u <= 5 && r >= 6) return {1'b1, 4'(5 * (r - 6) + u - 1)};
        if (u >= 6 && u <= 7) return {1'b1, 4'(2 * (r - 1) + u - 6)};
        if (u >= 8 && r >= 4) return {1'b1, 4'(3 * (r - 4) + u - 8)};
        return 5'h00;
    endfunction
    // the observer drains every note queued since the last falling edge
    always @(negedge clk_in) begin
        logic [3:0] k;
        logic [19:0] v;
        while (exp_q.size() > 0) begin
            {k, v} = exp_q.pop_front();
            case (k)
                4'h0: check({12'h0, address_valid_out, bus_address_out & {7{address_valid_out}}}, v);
                4'h1: check({7'h0, rs485_mode_out, bay_code_out, slot_code_out, shelf_code_out}, v);
                4'h2: check({3'h0, sw_owns_out, setpoint_out}, v);
                4'h3: check({19'h0, main_output_on_out}, v);
                4'h4: check({19'h0, ack_out}, v);
                default: check({19'h0, invalid_cmd_out}, v);
            endcase
        end
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int s, h;
        logic [4:0] a;
        logic [3:0] g;
        {unit_position_strap_in, rack_position_strap_in, slot_position_strap_in} = '0;
        {shelf_position_level_in, vprog_mv_in} = {12'h019, 12'hce4};
        {protocol_strap_open_in, slot_sense_tied_in, interlock_tied_in, on_off_n_in} = 4'he;
        void'($urandom(66934));
        tick(20);
        reset_in = 1'b0;
        tick(3);
        for (int u = 1; u <= 10; u++) begin
            for (int r = 1; r <= 8; r++) begin
                unit_position_strap_in = unit_mv[u] + 12'($urandom_range(40));
                rack_position_strap_in = rack_mv[r] + 12'($urandom_range(40));
                tick(4);
                a = exp_addr(u, r);
                put(4'h0, a[4] ? {12'h0, 1'b1, 3'b100, a[3:0]} : 20'h0);
            end
        end
        unit_position_strap_in = 12'hce4;
        tick(4);
        put(4'h0, 20'h0);
        $display("test address map done");
        protocol_strap_open_in = 1'b0;
        repeat (12) begin
            s = $urandom_range(1, 10);
            h = $urandom_range(1, 10);
            unit_position_strap_in = unit_mv[h];
            slot_position_strap_in = unit_mv[s];
            shelf_position_level_in = 12'(25 * h);
            tick(4);
            put(4'h1, {7'h0, 1'b1, 4'(h), 4'(s), 4'(h)});
            put(4'h0, 20'h0);
        end
        {slot_position_strap_in, shelf_position_level_in} = {12'hce4, 12'h00a};
        tick(4);
        put(4'h1, {7'h0, 1'b1, 4'(h), 8'h00});
        $display("test rs485 codes done");
        repeat (40) begin
            g = 4'($urandom());
            {protocol_strap_open_in, slot_sense_tied_in, interlock_tied_in, on_off_n_in} = g;
            tick(4);
            put(4'h3, {19'h0, g[2] & g[1] & (!g[3] | !g[0])});
        end
        $display("test output gating done");
        {protocol_strap_open_in, slot_sense_tied_in, interlock_tied_in, on_off_n_in} = 4'he;
        {unit_position_strap_in, rack_position_strap_in, vprog_mv_in} = {12'hbb8, 12'hce4, 12'h5dc};
        tick(4);
        put(4'h2, 20'h013ec);
        put(4'h0, 20'h000c0);
        vprog_mv_in = 12'hbb8;
        tick(4);
        put(4'h2, 20'h016a8);
        vprog_mv_in = 12'hce4;
        tick(4);
        put(4'h2, 20'h01518);
        // first three commands back to back: valid stays up between them
        host.issue(7'h41, 1'b0, 1'b1, 1'b0, 16'h1400, 1'b0, 1'b0);
        put(4'h4, 20'h0);
        host.issue(7'h00, 1'b0, 1'b1, 1'b0, 16'h1388, 1'b0, 1'b0);
        put(4'h4, 20'h1);
        host.issue(7'h40, 1'b0, 1'b1, 1'b0, 16'h1450, 1'b0, 1'b1);
        put(4'h4, 20'h1);
        put(4'h2, 20'h11388);
        tick(1);
        put(4'h2, 20'h11450);
        vprog_mv_in = 12'h5dc;
        tick(4);
        put(4'h2, 20'h11450);
        host.issue(7'h00, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b0, 1'b1);
        tick(2);
        put(4'h3, 20'h0);
        host.issue(7'h40, 1'b0, 1'b0, 1'b1, 16'h0001, 1'b0, 1'b1);
        tick(2);
        put(4'h3, 20'h1);
        host.issue(7'h40, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        put(4'h4, 20'h1);
        put(4'h5, 20'h0);
        host.issue(7'h00, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b1);
        put(4'h5, 20'h1);
        tick(3);
        put(4'h5, 20'h1);
        reset_in = 1'b1;
        tick(2);
        reset_in = 1'b0;
        tick(4);
        put(4'h2, 20'h013ec);
        put(4'h3, 20'h1);
        put(4'h5, 20'h0);
        $display("test commands done");
        tick(2);
        wrap_up();
    end
endmodule

// File: rtl/raoc_pkg.sv
// package: constants, thresholds and codes for the rectifier address and output control block
// What this block does
// - unit strap level quantized to units one to ten; pulled-up level is invalid
// - rack strap level quantized to racks one to eight; open is rack one
// - units 1-4, racks 1-4: address is 4*(rack-1)+(unit-1)
// - units 1-5, racks 6-8: address is 5*(rack-6)+(unit-1); rack five none
// - units 6-7: 2*(rack-1)+(unit-6); units 8-10, racks 4-8: 3*(rack-4)+(unit-8)
// - bus address is binary 100 plus four address bits; broadcast is zero
// - protocol strap open selects two-wire mode, resistor selects RS485 mode
// - main output only while slot sense is tied to output return
// - RS485 address is built from bay, slot and shelf codes
// - in RS485 mode the unit number is reused as bay code
// - slot strap quantized like unit strap to slots one to ten; 3.3 V invalid
// - shelf level is 2.5 V per shelf; decoded to shelves one to ten
// - writes to broadcast address are accepted and executed
// - a read to broadcast address enters the invalid-command state
// - hardware setpoint followed until a software setpoint executes, then ignored
// - after bias power cycles, setpoint again comes from hardware input
// - hardware setpoint above 3 V selects factory default setpoint
// - below threshold, hardware level maps to setpoint between 44 V and 58 V
// - in two-wire or analog mode output needs the active-low on/off low
// - output turns off as soon as on/off or interlock is released
// - output on only while short interlock contact is connected
// - in RS485 mode on/off input is ignored
package raoc_pkg;
    // ------------------------------------------------------------
    // strap levels, in millivolts as 12-bit codes; shelf level in 100 mV units
    // ------------------------------------------------------------
    localparam int LVL_W = 12;
    // unit and slot straps: lower bound of each step (midpoints between table levels)
    localparam logic [11:0] STEP10_INVALID_MV = 12'hc4e; // 3.15 V and above is the pulled-up level
    // lower bounds for units 1..9 top-down: 2835,2505,2175,1845,1515,1185,855,525,180
    localparam logic [11:0] STEP10_BOUND_ACT [0:8] = '{
        12'hb13, 12'h9c9, 12'h87f, 12'h735, 12'h5eb, 12'h4a1, 12'h357, 12'h20d, 12'h0b4};
    // rack strap lower bounds for racks 1..7 (midpoints)
    localparam logic [11:0] RACK_BOUND_MV [0:6] = '{
        12'hbea, 12'h9f6, 12'h802, 12'h640, 12'h4b0, 12'h2ee, 12'h0fa};
    // shelf level, 100 mV units, lower bounds for shelves 1..10
    localparam logic [11:0] SHELF_BOUND [0:9] = '{
        12'h017, 12'h02f, 12'h04a, 12'h05f, 12'h076, 12'h08e, 12'h0a6, 12'h0be, 12'h0d5, 12'h0ee};
    localparam logic [11:0] SHELF_MAX = 12'h107; // 26.3 V
    // setpoint input
    localparam logic [11:0] VPROG_DEFAULT_MV = 12'hbb8; // 3 V
    localparam logic [11:0] VOUT_SPAN_CV = 12'h578; // 14.00 V span in 10 mV
    localparam logic [15:0] VOUT_MIN_CV16 = 16'h1130; // 44.00 V in 10 mV
    localparam logic [15:0] VOUT_DEFAULT_CV16 = 16'h1518; // 54.00 V
    // bus addresses
    localparam logic [2:0] ADDR_PREFIX = 3'b100;
    localparam logic [6:0] ADDR_BROADCAST = 7'h00;
    typedef enum {RAOC_TWO_WIRE, RAOC_RS485} raoc_mode_e;
endpackage

// File: rtl/raoc_setpoint.sv
// setpoint select: hardware input until software takes over
`timescale 1ns/10ps
module raoc_setpoint (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [11:0] vprog_mv_in,
    input wire logic sw_set_in,
    input wire logic [15:0] sw_value_in,
    output logic [15:0] setpoint_out,
    output logic sw_owns_out
);
    logic sw_owns_q;
    logic [15:0] setpoint_q;
    logic [15:0] hw_value;
    logic [27:0] scaled;
    // linear map of 0..3 V onto 44..58 V
    always_comb begin
        scaled = 28'(vprog_mv_in) * 28'(raoc_pkg::VOUT_SPAN_CV);
        if (vprog_mv_in > raoc_pkg::VPROG_DEFAULT_MV) begin
            hw_value = raoc_pkg::VOUT_DEFAULT_CV16;
        end else begin
            hw_value = raoc_pkg::VOUT_MIN_CV16 + 16'(scaled / 28'(raoc_pkg::VPROG_DEFAULT_MV));
        end
    end
    // ownership only returns to hardware through reset, i.e. a bias cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sw_owns_q <= 1'b0;
        end else if (sw_set_in) begin
            sw_owns_q <= 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            setpoint_q <= raoc_pkg::VOUT_DEFAULT_CV16;
        end else if (sw_set_in) begin
            setpoint_q <= sw_value_in;
        end else if (!sw_owns_q) begin
            setpoint_q <= hw_value;
        end
    end
    assign setpoint_out = setpoint_q;
    assign sw_owns_out = sw_owns_q;
endmodule

// File: rtl/raoc_step_decode.sv
// quantizer: strap level to position number
`timescale 1ns/10ps
module raoc_step_decode #(
    parameter int STEPS = 10
) (
    input wire logic [11:0] level_in,
    input wire logic [11:0] bounds_in [0:STEPS-2],
    input wire logic [11:0] invalid_in,
    output logic [3:0] number_out,
    output logic valid_out
);
    // bounds fall from step one; a level at or above bound k is step k+1
    always_comb begin
        number_out = 4'(STEPS);
        valid_out = (level_in < invalid_in);
        for (int k = STEPS - 2; k >= 0; k--) begin
            if (level_in >= bounds_in[k]) begin
                number_out = 4'(k + 1);
            end
        end
        if (!valid_out) begin
            number_out = 4'h0;
        end
    end
endmodule

// File: rtl/raoc_top.sv
// top: address derivation, broadcast handling and main output gating
`timescale 1ns/10ps
module raoc_top (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [11:0] unit_position_strap_in,
    input wire logic [11:0] rack_position_strap_in,
    input wire logic [11:0] slot_position_strap_in,
    input wire logic [11:0] shelf_position_level_in,
    input wire logic [11:0] vprog_mv_in,
    input wire logic protocol_strap_open_in,
    input wire logic slot_sense_tied_in,
    input wire logic interlock_tied_in,
    input wire logic on_off_n_in,
    input wire logic cmd_valid_in,
    input wire logic [6:0] cmd_addr_in,
    input wire logic cmd_read_in,
    input wire logic cmd_setpoint_in,
    input wire logic cmd_output_in,
    input wire logic [15:0] cmd_data_in,
    output logic [6:0] bus_address_out,
    output logic address_valid_out,
    output logic [3:0] bay_code_out,
    output logic [3:0] slot_code_out,
    output logic [3:0] shelf_code_out,
    output logic rs485_mode_out,
    output logic ack_out,
    output logic invalid_cmd_out,
    output logic [15:0] setpoint_out,
    output logic sw_owns_out,
    output logic main_output_on_out
);
    // ------------------------------------------------------------
    // address table
    // ------------------------------------------------------------
    function automatic logic [4:0] addr_map(input logic [3:0] u, input logic [3:0] r);
        logic [7:0] a;
        logic ok;
        a = 8'h00;
        ok = 1'b0;
        if (u >= 4'd1 && u <= 4'd4 && r >= 4'd1 && r <= 4'd4) begin
            a = 8'(4 * (r - 1) + (u - 1));
            ok = 1'b1;
        end else if (u >= 4'd1 && u <= 4'd5 && r >= 4'd6 && r <= 4'd8) begin
            a = 8'(5 * (r - 6) + (u - 1));
            ok = 1'b1;
        end else if ((u == 4'd6 || u == 4'd7) && r >= 4'd1 && r <= 4'd8) begin
            a = 8'(2 * (r - 1) + (u - 6));
            ok = 1'b1;
        end else if (u >= 4'd8 && u <= 4'd10 && r >= 4'd4 && r <= 4'd8) begin
            a = 8'(3 * (r - 4) + (u - 8));
            ok = 1'b1;
        end
        return {ok, a[3:0]};
    endfunction

    // ------------------------------------------------------------
    // strap decoding
    // ------------------------------------------------------------
    logic [3:0] unit_num;
    logic unit_ok;
    logic [3:0] slot_num;
    logic slot_ok;
    logic [3:0] rack_num;
    logic [3:0] shelf_num;
    logic shelf_ok;
    logic [4:0] addr_bits;

    raoc_step_decode #(.STEPS(10)) u_unit (
        .level_in(unit_position_strap_in),
        .bounds_in(raoc_pkg::STEP10_BOUND_ACT),
        .invalid_in(raoc_pkg::STEP10_INVALID_MV),
        .number_out(unit_num),
        .valid_out(unit_ok)
    );

    raoc_step_decode #(.STEPS(10)) u_slot (
        .level_in(slot_position_strap_in),
        .bounds_in(raoc_pkg::STEP10_BOUND_ACT),
        .invalid_in(raoc_pkg::STEP10_INVALID_MV),
        .number_out(slot_num),
        .valid_out(slot_ok)
    );

    // rack uses a falling-bound scan, shelf a rising-bound scan; rack has no invalid level
    always_comb begin
        rack_num = 4'd8;
        for (int k = 6; k >= 0; k--) begin
            if (rack_position_strap_in >= raoc_pkg::RACK_BOUND_MV[k]) begin
                rack_num = 4'(k + 1);
            end
        end
    end

    always_comb begin
        shelf_num = 4'h0;
        shelf_ok = 1'b0;
        for (int k = 0; k < 10; k++) begin
            if (shelf_position_level_in >= raoc_pkg::SHELF_BOUND[k]) begin
                shelf_num = 4'(k + 1);
                shelf_ok = 1'b1;
            end
        end
        if (shelf_position_level_in > raoc_pkg::SHELF_MAX) begin
            shelf_num = 4'h0;
            shelf_ok = 1'b0;
        end
    end

    assign addr_bits = unit_ok ? addr_map(unit_num, rack_num) : 5'h00;

    // ------------------------------------------------------------
    // mode and address registers
    // ------------------------------------------------------------
    logic rs485_q;
    logic [6:0] addr_q;
    logic addr_ok_q;
    logic [3:0] bay_q;
    logic [3:0] slot_q;
    logic [3:0] shelf_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rs485_q <= 1'b0;
        end else begin
            rs485_q <= !protocol_strap_open_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            addr_q <= 7'h00;
            addr_ok_q <= 1'b0;
        end else begin
            addr_q <= {raoc_pkg::ADDR_PREFIX, addr_bits[3:0]};
            addr_ok_q <= addr_bits[4] && !rs485_q;
        end
    end

    // rs485 identity: bay from unit strap, plus slot and shelf
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bay_q <= 4'h0;
            slot_q <= 4'h0;
            shelf_q <= 4'h0;
        end else begin
            bay_q <= unit_num;
            slot_q <= slot_ok ? slot_num : 4'h0;
            shelf_q <= shelf_ok ? shelf_num : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic is_bcast;
    logic is_mine;
    logic exec_write;
    logic ack_q;
    logic invalid_q;
    logic sw_out_on_q;

    assign is_bcast = cmd_addr_in == raoc_pkg::ADDR_BROADCAST;
    assign is_mine = addr_ok_q && cmd_addr_in == addr_q;
    // broadcast write runs like an addressed one; a broadcast read never does
    assign exec_write = cmd_valid_in && !cmd_read_in && (is_mine || is_bcast);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cmd_valid_in && (is_mine || is_bcast);
        end
    end

    // invalid-command state holds until reset; no clear path exists here
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            invalid_q <= 1'b0;
        end else if (cmd_valid_in && cmd_read_in && is_bcast) begin
            invalid_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sw_out_on_q <= 1'b1;
        end else if (exec_write && cmd_output_in) begin
            sw_out_on_q <= cmd_data_in[0];
        end
    end

    // ------------------------------------------------------------
    // setpoint
    // ------------------------------------------------------------
    logic [15:0] setpoint;
    logic sw_owns;

    raoc_setpoint u_setpoint (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .vprog_mv_in(vprog_mv_in),
        .sw_set_in(exec_write && cmd_setpoint_in),
        .sw_value_in(cmd_data_in),
        .setpoint_out(setpoint),
        .sw_owns_out(sw_owns)
    );

    logic [15:0] setpoint_q;
    logic sw_owns_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            setpoint_q <= raoc_pkg::VOUT_DEFAULT_CV16;
            sw_owns_q <= 1'b0;
        end else begin
            setpoint_q <= setpoint;
            sw_owns_q <= sw_owns;
        end
    end

    // ------------------------------------------------------------
    // main output gating
    // ------------------------------------------------------------
    logic on_q;
    logic enable_d;
    always_comb begin
        // interlock and slot sense both needed; on/off counts only outside rs485
        enable_d = interlock_tied_in && slot_sense_tied_in && sw_out_on_q;
        if (!rs485_q) begin
            enable_d = enable_d && !on_off_n_in;
        end
    end
    // one-cycle path; release of either contact drops output next edge
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            on_q <= 1'b0;
        end else begin
            on_q <= enable_d;
        end
    end

    assign bus_address_out = addr_q;
    assign address_valid_out = addr_ok_q;
    assign bay_code_out = bay_q;
    assign slot_code_out = slot_q;
    assign shelf_code_out = shelf_q;
    assign rs485_mode_out = rs485_q;
    assign ack_out = ack_q;
    assign invalid_cmd_out = invalid_q;
    assign setpoint_out = setpoint_q;
    assign sw_owns_out = sw_owns_q;
    assign main_output_on_out = on_q;
endmodule
